// file: dv/tcm_capture_timer_props.sv
// Port-level assertions of the capture timer
`timescale 1ns/1ns
module tcm_capture_timer_props
  import tcm_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        countTick,
  input wire logic        triggerInZero,
  input wire logic        triggerInOne,
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrStb,
  input wire logic        regRdStb,
  input wire logic [15:0] regRdData,
  input wire logic [1:0]  captureIrq,
  input wire logic        wrapIrq,
  input wire logic [7:0]  outputControl
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Read data shows only in the slot after a strobe
  chk_rd_idle: assert property (
    !$past(regRdStb) |-> regRdData == 16'h0000) else $error("read data outside slot");
  chk_rd_unmapped: assert property (
    regRdStb && regAddr > ADDR_CAPTURE1 |=> regRdData == 16'h0000) else $error("unmapped read");
  // A capture pulse needs a pin change one cycle earlier
  chk_cap0_cause: assert property (
    captureIrq[0] |-> $past(triggerInZero) != $past(triggerInZero, 2))
    else $error("capture 0 without edge");
  chk_cap1_cause: assert property (
    captureIrq[1] |-> $past(triggerInOne) != $past(triggerInOne, 2))
    else $error("capture 1 without edge");
  chk_wrap_single: assert property (
    wrapIrq |=> !wrapIrq) else $error("wrap irq too long");
  chk_wrap_tick: assert property (
    wrapIrq |-> $past(countTick || triggerInZero)) else $error("wrap without count step");
  // Flag reads set in the wrap cycle, even against a clear
  chk_flag_set: assert property (
    wrapIrq && regRdStb && regAddr == ADDR_OPTION0 |=> regRdData[WRAP_FLAG_POS])
    else $error("flag not set on wrap");
  chk_rst_quiet: assert property (
    $rose(rstn) |-> captureIrq == 2'b00 && !wrapIrq) else $error("irq after reset");
endmodule
bind tcm_capture_timer tcm_capture_timer_props #(.CNT_WIDTH(CNT_WIDTH)) u_tcm_capture_timer_props (
  .core_clk(core_clk), .rstn(rstn), .countTick(countTick), .triggerInZero(triggerInZero),
  .triggerInOne(triggerInOne), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
  .regRdStb(regRdStb), .regRdData(regRdData), .captureIrq(captureIrq), .wrapIrq(wrapIrq),
  .outputControl(outputControl));

// file: dv/tcm_capture_timer_tb.sv
// Self-checking bench of the capture timer with two pulse sources
`timescale 1ns/1ns
module tcm_capture_timer_tb
  import tcm_pkg::*;
();
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        countTick = 1'b0;
  logic        go0 = 1'b0;
  logic        go1 = 1'b0;
  logic [7:0]  per1 = 8'h14;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic        regWrStb = 1'b0;
  logic        regRdStb = 1'b0;
  logic        rdPend = 1'b0;
  logic        triggerInZero, triggerInOne, wrapIrq;
  logic [15:0] regRdData, m, kk;
  logic [1:0]  captureIrq;
  logic [7:0]  outputControl;
  logic [31:0] seed = 32'h00000040;
  logic [31:0] k;
  logic [15:0] expQ[$];
  logic [15:0] mskQ[$];
  int          errors = 0;
  int          n_tests = 0;
  int          nWraps = 0;
  int          wrapBase;
  logic [31:0] wid;
  logic [15:0] older, newer;
  tcm_capture_timer u_tcm_capture_timer (.core_clk(core_clk), .rstn(rstn), .countTick(countTick),
    .triggerInZero(triggerInZero), .triggerInOne(triggerInOne), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .captureIrq(captureIrq), .wrapIrq(wrapIrq), .outputControl(outputControl));
  tcm_pulse_src u_tcm_pulse_src (.core_clk(core_clk), .go(go0), .period(8'h07), .pin(triggerInZero));
  tcm_pulse_src u_tcm_pulse_src_one (.core_clk(core_clk), .go(go1), .period(per1), .pin(triggerInOne));
  always #5 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [15:0] exp, got, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge core_clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, msk);
    @(posedge core_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    expQ.push_back(e & msk);
    mskQ.push_back(msk);
    @(posedge core_clk);
    regRdStb <= 1'b0;
  endtask
  // Read that also hands the data back, in the slot where it stands
  task automatic rdv(input logic [3:0] a, output logic [15:0] v);
    rd(a, 16'h0000, 16'h0000);
    @(posedge core_clk);
    v = regRdData;
  endtask
  // Bounded wait for a capture on input one
  task automatic waitIrq();
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (captureIrq[1] !== 1'b1 && i < 300);
    check(16'h0001, {15'h0000, captureIrq[1]}, "capture irq 1");
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Read results are compared one slot after their strobe; input zero never captures
  always @(posedge core_clk) begin
    if (rdPend) begin
      m = mskQ.pop_front();
      check(expQ.pop_front(), regRdData & m, "read data");
    end
    // Outputs are unknown until the first reset edge, so only look once out of reset
    if (rstn && captureIrq[0] !== 1'b0) check(16'h0000, {15'h0000, captureIrq[0]}, "capture irq 0");
    rdPend <= regRdStb;
  end
  // Wrap count kept by the bench, as an overflow handler would keep it
  always @(posedge core_clk) begin
    if (wrapIrq === 1'b1) nWraps <= nWraps + 1;
  end
  // Watchdog sized for one full wrap plus short scenarios
  initial begin
    #1000000;
    errors++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 10; i++) rd(i[3:0], 16'h0000, 16'hFFFF);
    go0 <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      k = xs();
      countTick <= k[0];
    end
    rd(ADDR_COUNTER, 16'h0000, 16'hFFFF);
    wr(ADDR_EDGE_CFG, {12'h000, EDGE_RISE, EDGE_NONE});
    wr(ADDR_OUT_CTRL, 16'h00A5);
    wr(ADDR_RUN_CTRL, {8'h00, 1'b1, 4'h0, MODE_WIDTH});
    countTick <= 1'b1;
    k = xs();
    per1 <= 8'd20 + {2'b00, k[5:0]};
    go1 <= 1'b1;
    waitIrq();
    waitIrq();
    go1 <= 1'b0;
    countTick <= 1'b0;
    check(16'h0000, {8'h00, outputControl}, "output control");
    rd(ADDR_CAPTURE1, {8'h00, per1} - 16'h0001, 16'hFFFF);
    rd(ADDR_COUNTER, 16'h0001, 16'hFFFF);
    // Run to FFFF with a bit-clear landing on the wrap edge itself
    countTick <= 1'b1;
    repeat (65533) @(posedge core_clk);
    wr(ADDR_FLAG_CLR, 16'h0001);
    regAddr <= ADDR_OPTION0;
    regRdStb <= 1'b1;
    expQ.push_back(16'h0001);
    mskQ.push_back(16'h0001);
    @(posedge core_clk);
    check(16'h0001, {15'h0000, wrapIrq}, "wrap irq");
    regRdStb <= 1'b0;
    countTick <= 1'b0;
    rd(ADDR_COUNTER, 16'h0001, 16'hFFFF);
    wr(ADDR_FLAG_CLR, 16'h0001);
    rd(ADDR_OPTION0, 16'h0000, 16'h0001);
    check(16'h0001, nWraps[15:0], "wrap count");
    // Free-running capture keeps the count
    wr(ADDR_RUN_CTRL, 16'h0000);
    rd(ADDR_COUNTER, 16'h0000, 16'hFFFF);
    wr(ADDR_OPTION0, 16'h0020);
    wr(ADDR_CAPTURE0, 16'h1234);
    wr(ADDR_RUN_CTRL, {8'h00, 1'b1, 4'h0, MODE_FREE_RUN});
    k = xs();
    kk = {8'h00, k[7:0]} + 16'h0003;
    countTick <= 1'b1;
    repeat (kk) @(posedge core_clk);
    countTick <= 1'b0;
    go1 <= 1'b1;
    waitIrq();
    go1 <= 1'b0;
    check(16'h00A5, {8'h00, outputControl}, "output control");
    wr(ADDR_COUNTER, 16'hFFFF);
    rd(ADDR_CAPTURE1, kk, 16'hFFFF);
    rd(ADDR_COUNTER, kk, 16'hFFFF);
    rd(ADDR_CAPTURE0, 16'h1234, 16'hFFFF);
    rd(ADDR_OPTION0, 16'h0020, 16'h0021);
    // External count clock on input 0 (period 7), captures on input 1 every 70 cycles
    wrapBase = nWraps;
    wr(ADDR_RUN_CTRL, {8'h00, 1'b1, 4'h1, MODE_FREE_RUN});
    per1 <= 8'h46;
    go1 <= 1'b1;
    waitIrq();
    rdv(ADDR_CAPTURE1, older);
    waitIrq();
    rdv(ADDR_CAPTURE1, newer);
    go1 <= 1'b0;
    // Seventy cycles at one count per seven cycles gives ten counts
    wid = (nWraps - wrapBase) * 32'h00010000 + {16'h0000, newer} - {16'h0000, older};
    check(16'h000A, wid[15:0], "free-run width");
    repeat (2) @(posedge core_clk);
    end_sim();
  end
endmodule

// file: dv/tcm_pulse_src.sv
// Far-side pulse source driving one capture trigger pin
`timescale 1ns/1ns
module tcm_pulse_src (
  // Clock
  input  wire logic       core_clk,
  // Control from the bench
  input  wire logic       go,
  input  wire logic [7:0] period,
  // Trigger pin
  output logic            pin
);
  logic [7:0] phaseCnt;
  initial begin
    pin = 1'b0;
    phaseCnt = 8'h00;
  end
  // Rising edge every period cycles; pin parks low while idle so no stale level lingers
  always @(posedge core_clk) begin
    if (!go) begin
      pin <= 1'b0;
      phaseCnt <= 8'h00;
    end else begin
      pin <= phaseCnt < (period >> 1);
      phaseCnt <= (phaseCnt + 8'h01 == period) ? 8'h00 : phaseCnt + 8'h01;
    end
  end
endmodule

// file: hw/tcm_capture_timer.sv
// Capture and wrap logic of a 16-bit timer with two capture trigger inputs
`timescale 1ns/1ns

module tcm_capture_timer
  import tcm_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Count clock enable from the prescaler
  input  wire logic                 countTick,
  // Capture trigger pins, already filtered
  input  wire logic                 triggerInZero,
  input  wire logic                 triggerInOne,
  // Register port
  input  wire logic [3:0]           regAddr,
  input  wire logic [15:0]          regWrData,
  input  wire logic                 regWrStb,
  input  wire logic                 regRdStb,
  output logic      [15:0]          regRdData,
  // Interrupt requests, one-cycle pulses
  output logic      [1:0]           captureIrq,
  output logic                      wrapIrq,
  // Output control setting, forced to zero in width mode
  output logic      [7:0]           outputControl
);

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [7:0]           runControl_reg;
  logic [7:0]           edgeConfig_reg;
  logic [7:0]           outputControl_reg;
  logic [1:0]           captureSelect_reg;
  logic                 wrapFlag_reg;
  logic [CNT_WIDTH-1:0] counter_reg;
  logic [CNT_WIDTH-1:0] counter_next;
  logic [CNT_WIDTH-1:0] capture_reg [2];
  logic [1:0]           trigPrev_reg;
  logic [1:0]           captureIrq_reg;
  logic                 wrapIrq_reg;
  logic [15:0]          rdData_reg;

  // ----------------------------------------------------------------------------
  // Decode of control fields
  // ----------------------------------------------------------------------------
  logic       countRun;
  logic       extClock;
  logic [2:0] opSelect;
  tcm_op_type opState;
  logic [1:0] trigNow;
  logic [1:0] validEdge;
  logic [1:0] captureEn;
  logic       anyCapture;
  logic       countStep;
  logic       wrapEvent;
  logic       wrOption;
  logic       wrFlagClr;

  assign countRun = runControl_reg[RUN_BIT_POS];
  assign extClock = runControl_reg[EXT_CLK_POS];
  assign opSelect = runControl_reg[MODE_LSB +: 3];
  assign trigNow  = {triggerInOne, triggerInZero};

  // Mode field to counter behaviour
  always_comb begin
    case (opSelect)
      MODE_WIDTH:    opState = TCM_WIDTH;
      MODE_FREE_RUN: opState = TCM_FREE;
      default:       opState = TCM_IDLE;
    endcase
  end

  // Output control is passed on but gated off while measuring width
  assign outputControl = (opState == TCM_WIDTH) ? 8'h00 : outputControl_reg;

  // ----------------------------------------------------------------------------
  // Edge detection, one generate branch per trigger input
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gEdge
      logic [1:0] sel;
      logic       rise;
      logic       fall;
      assign sel  = edgeConfig_reg[(gi*2) +: 2];
      assign rise = trigNow[gi] & ~trigPrev_reg[gi];
      assign fall = ~trigNow[gi] & trigPrev_reg[gi];
      // A pin set to no edge never captures; software parks the unused one there
      assign validEdge[gi] = ((sel == EDGE_RISE) & rise) |
                             ((sel == EDGE_FALL) & fall) |
                             ((sel == EDGE_BOTH) & (rise | fall));
      // Width mode captures on either input; free-run only where selected as capture
      assign captureEn[gi] = countRun & validEdge[gi] &
                             ((opState == TCM_WIDTH) |
                              ((opState == TCM_FREE) & captureSelect_reg[gi]));
    end
  endgenerate

  assign anyCapture = |captureEn;

  // External count clock takes rising edges of input 0 in place of the prescaler tick
  assign countStep = countRun &
                     (extClock ? (triggerInZero & ~trigPrev_reg[0]) : countTick);
  // The tick after FFFF is the wrap; a width-mode capture in the same cycle clears instead
  assign wrapEvent = countStep & (counter_reg == COUNT_MAX[CNT_WIDTH-1:0]) &
                     ~((opState == TCM_WIDTH) & anyCapture);

  // Trigger pin history for edge detection
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trigPrev_reg <= 2'h0;
    end else begin
      trigPrev_reg <= trigNow;
    end
  end

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  always_comb begin
    counter_next = counter_reg;
    if (!countRun) begin
      counter_next = COUNT_RST[CNT_WIDTH-1:0];
    end else if ((opState == TCM_WIDTH) && anyCapture) begin
      counter_next = COUNT_RST[CNT_WIDTH-1:0];
    end else if (countStep) begin
      // Natural roll-over gives 0000 after FFFF in every mode
      counter_next = counter_reg + CNT_WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      counter_reg <= COUNT_RST[CNT_WIDTH-1:0];
    end else begin
      counter_reg <= counter_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Capture registers, loaded by hardware or by software writes
  // ----------------------------------------------------------------------------
  generate
    for (gi = 0; gi < 2; gi++) begin : gCap
      logic [3:0] myAddr;
      assign myAddr = (gi == 0) ? ADDR_CAPTURE0 : ADDR_CAPTURE1;
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          capture_reg[gi] <= COUNT_RST[CNT_WIDTH-1:0];
        end else if (captureEn[gi]) begin
          // Hardware capture wins over a software write in the same cycle
          capture_reg[gi] <= counter_reg;
        end else if (regWrStb && (regAddr == myAddr)) begin
          capture_reg[gi] <= regWrData[CNT_WIDTH-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Interrupt request pulses
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      captureIrq_reg <= 2'h0;
      wrapIrq_reg    <= 1'b0;
    end else begin
      captureIrq_reg <= captureEn;
      wrapIrq_reg    <= wrapEvent;
    end
  end

  assign captureIrq = captureIrq_reg;
  assign wrapIrq    = wrapIrq_reg;

  // ----------------------------------------------------------------------------
  // Control register writes
  // ----------------------------------------------------------------------------
  assign wrOption  = regWrStb & (regAddr == ADDR_OPTION0);
  assign wrFlagClr = regWrStb & (regAddr == ADDR_FLAG_CLR) & regWrData[WRAP_FLAG_POS];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      runControl_reg    <= RUN_CTRL_RST;
      edgeConfig_reg    <= EDGE_CFG_RST;
      outputControl_reg <= OUT_CTRL_RST;
      captureSelect_reg <= 2'h0;
    end else if (regWrStb) begin
      case (regAddr)
        ADDR_RUN_CTRL: runControl_reg    <= regWrData[7:0];
        ADDR_EDGE_CFG: edgeConfig_reg    <= regWrData[7:0];
        ADDR_OUT_CTRL: outputControl_reg <= regWrData[7:0];
        ADDR_OPTION0:  captureSelect_reg <= {regWrData[CAP_SEL1_POS], regWrData[CAP_SEL0_POS]};
        default:       ;
      endcase
    end
  end

  // Sticky wrap flag: one bit only, so repeated wraps collapse into one
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrapFlag_reg <= 1'b0;
    end else if (wrapEvent) begin
      // Set has priority so a clear racing a wrap cannot lose it
      wrapFlag_reg <= 1'b1;
    end else if (wrFlagClr || (wrOption && !regWrData[WRAP_FLAG_POS])) begin
      wrapFlag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Read port, data valid the cycle after the strobe
  // ----------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= 16'h0000;
    end else if (regRdStb) begin
      case (regAddr)
        ADDR_RUN_CTRL: rdData_reg <= {8'h00, runControl_reg};
        ADDR_EDGE_CFG: rdData_reg <= {8'h00, edgeConfig_reg};
        ADDR_OUT_CTRL: rdData_reg <= {8'h00, outputControl_reg};
        ADDR_OPTION0:  rdData_reg <= {10'h000, captureSelect_reg, 3'h0, wrapFlag_reg};
        ADDR_COUNTER:  rdData_reg <= counter_reg;
        ADDR_CAPTURE0: rdData_reg <= capture_reg[0];
        ADDR_CAPTURE1: rdData_reg <= capture_reg[1];
        default:       rdData_reg <= 16'h0000;
      endcase
    end else begin
      rdData_reg <= 16'h0000;
    end
  end

  assign regRdData = rdData_reg;

endmodule

// file: hw/tcm_pkg.sv
// Package with register map, field positions, reset values and modes of the capture timer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package tcm_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_RUN_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_EDGE_CFG   = 4'h1;
  localparam logic [3:0] ADDR_OUT_CTRL   = 4'h2;
  localparam logic [3:0] ADDR_OPTION0    = 4'h3;
  localparam logic [3:0] ADDR_FLAG_CLR   = 4'h4;
  localparam logic [3:0] ADDR_COUNTER    = 4'h5;
  localparam logic [3:0] ADDR_CAPTURE0   = 4'h6;
  localparam logic [3:0] ADDR_CAPTURE1   = 4'h7;

  // Field positions
  localparam int RUN_BIT_POS      = 7;
  localparam int EXT_CLK_POS      = 3;
  localparam int MODE_LSB         = 0;
  localparam int EDGE0_LSB        = 0;
  localparam int EDGE1_LSB        = 2;
  localparam int CAP_SEL1_POS     = 5;
  localparam int CAP_SEL0_POS     = 4;
  localparam int WRAP_FLAG_POS    = 0;

  // Reset values
  localparam logic [7:0]  RUN_CTRL_RST  = 8'h00;
  localparam logic [7:0]  EDGE_CFG_RST  = 8'h00;
  localparam logic [7:0]  OUT_CTRL_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;

  // Operating modes held in the three-bit mode field
  localparam logic [2:0] MODE_FREE_RUN  = 3'h5;
  localparam logic [2:0] MODE_WIDTH     = 3'h6;

  // Edge selections
  localparam logic [1:0] EDGE_NONE      = 2'h0;
  localparam logic [1:0] EDGE_RISE      = 2'h1;
  localparam logic [1:0] EDGE_FALL      = 2'h2;
  localparam logic [1:0] EDGE_BOTH      = 2'h3;

  // Counter behaviour derived from the mode field
  typedef enum logic [2:0] {
    TCM_IDLE   = 3'b001,
    TCM_FREE   = 3'b010,
    TCM_WIDTH  = 3'b100
  } tcm_op_type;

endpackage
